// file: rtl/bcu_chan.sv
`include "bcu_map.svh"

module bcu_chan #(
   parameter bit HAS_DATA = 1'b0
) (
   input  wire logic [31:0]       cyc_addr,
   input  wire bcu_pkg::bcu_asid_t cyc_asid,
   input  wire logic              cyc_fetch,
   input  wire logic              cyc_write,
   input  wire bcu_pkg::bcu_size_e cyc_size,
   input  wire logic [31:0]       cyc_data,
   input  wire logic [31:0]       cfg_addr,
   input  wire bcu_pkg::bcu_asid_t cfg_asid,
   input  wire logic [7:0]        cfg_mask,
   input  wire logic [15:0]       cfg_cond,
   input  wire logic [31:0]       cfg_data,
   input  wire logic [31:0]       cfg_dmask,
   input  wire logic              cfg_den,
   output logic                   hit
);

   logic [31:0] care;
   logic [1:0]  kind;
   logic [1:0]  dir;
   logic [1:0]  size;
   logic        addr_ok;
   logic        asid_ok;
   logic        kind_ok;
   logic        dir_ok;
   logic        size_ok;
   logic        data_ok;

   always_comb begin
      kind = cfg_cond[`BCU_COND_KIND_HI:`BCU_COND_KIND_LO];
      dir  = cfg_cond[`BCU_COND_DIR_HI:`BCU_COND_DIR_LO];
      size = cfg_cond[`BCU_COND_SIZE_HI:`BCU_COND_SIZE_LO];
      unique case (bcu_pkg::bcu_amask_e'(cfg_mask[`BCU_MASK_ADDR_HI:`BCU_MASK_ADDR_LO]))
         bcu_pkg::BCU_AM_ALL:  care = `BCU_CARE_ALL;
         bcu_pkg::BCU_AM_LO10: care = `BCU_CARE_10;
         bcu_pkg::BCU_AM_LO12: care = `BCU_CARE_12;
         bcu_pkg::BCU_AM_NONE: care = `BCU_CARE_NONE;
      endcase
      addr_ok = ((cyc_addr ^ cfg_addr) & care) == 32'h00000000;
      // all eight id bits or none
      asid_ok = cfg_mask[`BCU_MASK_ASID_BIT] || (cyc_asid == cfg_asid);
      kind_ok = (kind == 2'h0) || (kind[0] && cyc_fetch) || (kind[1] && !cyc_fetch);
      dir_ok  = (dir == 2'h0) || (dir[0] && !cyc_write) || (dir[1] && cyc_write);
      size_ok = (size == 2'h0) || (size == 2'(cyc_size));
      // mask bit set drops that data bit
      data_ok = !HAS_DATA || !cfg_den
                || (((cyc_data ^ cfg_data) & ~cfg_dmask) == 32'h00000000);
      // a channel with no kind and no direction is idle, else reset would trap forever
      hit = ((kind != 2'h0) || (dir != 2'h0))
            && addr_ok && asid_ok && kind_ok && dir_ok && size_ok && data_ok;
   end

endmodule : bcu_chan

// file: rtl/bcu_map.svh
`ifndef BCU_MAP_SVH
`define BCU_MAP_SVH

// register addresses
`define BCU_OFS_MASK_A      32'h0FFFFFB4
`define BCU_OFS_COND_A      32'h0FFFFFB8
`define BCU_OFS_ASID_B      32'h0FFFFFE8
`define BCU_OFS_DATA_B      32'hFFFFFF90
`define BCU_OFS_DMASK_B     32'hFFFFFF94
`define BCU_OFS_CTL         32'hFFFFFF98
`define BCU_OFS_ADDR_B      32'hFFFFFFA0
`define BCU_OFS_MASK_B      32'hFFFFFFA4
`define BCU_OFS_COND_B      32'hFFFFFFA8
`define BCU_OFS_ADDR_A      32'hFFFFFFB0
`define BCU_OFS_ASID_A      32'hFFFFFFE4

// writable bits and reset values
`define BCU_COND_WMASK      16'h003F
`define BCU_COND_RST        16'h0000
`define BCU_CTL_WMASK       16'hC4C8
`define BCU_CTL_RST         16'h0000
`define BCU_MASK_WMASK      8'h07

// bus-cycle condition fields
`define BCU_COND_KIND_HI    5
`define BCU_COND_KIND_LO    4
`define BCU_COND_DIR_HI     3
`define BCU_COND_DIR_LO     2
`define BCU_COND_SIZE_HI    1
`define BCU_COND_SIZE_LO    0

// mask register fields
`define BCU_MASK_ASID_BIT   2
`define BCU_MASK_ADDR_HI    1
`define BCU_MASK_ADDR_LO    0

// common control fields
`define BCU_CTL_MFA         15
`define BCU_CTL_MFB         14
`define BCU_CTL_FETCH_TIMING_SEL_A        10
`define BCU_CTL_DATA_COND_ENABLE_B        7
`define BCU_CTL_FETCH_TIMING_SEL_B        6
`define BCU_CTL_SEQ         3

// address care masks
`define BCU_CARE_ALL        32'hFFFFFFFF
`define BCU_CARE_10         32'hFFFFFC00
`define BCU_CARE_12         32'hFFFFF000
`define BCU_CARE_NONE       32'h00000000

`endif

// file: rtl/bcu_pkg.sv
package bcu_pkg;

   typedef enum logic [1:0] {
      BCU_AM_ALL  = 2'b00,
      BCU_AM_LO10 = 2'b01,
      BCU_AM_LO12 = 2'b10,
      BCU_AM_NONE = 2'b11
   } bcu_amask_e;

   typedef enum logic [1:0] {
      BCU_SZ_NONE = 2'b00,
      BCU_SZ_BYTE = 2'b01,
      BCU_SZ_WORD = 2'b10,
      BCU_SZ_LONG = 2'b11
   } bcu_size_e;

   typedef logic [7:0] bcu_asid_t;

endpackage : bcu_pkg

// file: rtl/bcu_top.sv
`include "bcu_map.svh"

module bcu_top (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire logic [31:0]        reg_addr,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   input  wire bcu_pkg::bcu_size_e reg_size,
   input  wire logic [31:0]        reg_wdata,
   output logic [31:0]             reg_rdata,
   output logic                    reg_ack,
   output logic                    reg_err,
   input  wire logic               cyc_valid,
   input  wire logic [31:0]        cyc_addr,
   input  wire logic [31:0]        cyc_data,
   input  wire logic               cyc_fetch,
   input  wire logic               cyc_write,
   input  wire bcu_pkg::bcu_size_e cyc_size,
   input  wire bcu_pkg::bcu_asid_t mmu_page_entry_high,
   output logic                    break_req,
   output logic                    break_post
);

   // registers with a reset value
   logic [15:0] cond_a_r, cond_a_nxt;
   logic [15:0] cond_b_r, cond_b_nxt;
   logic [15:0] ctl_r, ctl_nxt;
   logic        seq_rec_r, seq_rec_nxt;
   logic        break_req_r, break_req_nxt;
   logic        break_post_r, break_post_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic        ack_r, ack_nxt;
   logic        err_r, err_nxt;

   // registers kept through reset
   logic [31:0]        addr_a_r, addr_a_nxt;
   logic [31:0]        addr_b_r, addr_b_nxt;
   bcu_pkg::bcu_asid_t asid_a_r, asid_a_nxt;
   bcu_pkg::bcu_asid_t asid_b_r, asid_b_nxt;
   logic [7:0]         mask_a_r, mask_a_nxt;
   logic [7:0]         mask_b_r, mask_b_nxt;
   logic [31:0]        data_b_r, data_b_nxt;
   logic [31:0]        dmask_b_r, dmask_b_nxt;

   logic                hit_a;
   logic                hit_b;
   logic                a_m;
   logic                b_m;
   logic                seq_on;
   logic                brk;
   logic                dec_hit;
   logic                acc_ok;
   logic                wr_ok;
   bcu_pkg::bcu_size_e  need_size;
   logic [31:0]         rd_val;

   bcu_chan #(.HAS_DATA(1'b0)) u_chan_a (
      .cyc_addr  (cyc_addr),
      .cyc_asid  (mmu_page_entry_high),
      .cyc_fetch (cyc_fetch),
      .cyc_write (cyc_write),
      .cyc_size  (cyc_size),
      .cyc_data  (cyc_data),
      .cfg_addr  (addr_a_r),
      .cfg_asid  (asid_a_r),
      .cfg_mask  (mask_a_r),
      .cfg_cond  (cond_a_r),
      .cfg_data  (32'h00000000),
      .cfg_dmask (32'hFFFFFFFF),
      .cfg_den   (1'b0),
      .hit       (hit_a)
   );

   bcu_chan #(.HAS_DATA(1'b1)) u_chan_b (
      .cyc_addr  (cyc_addr),
      .cyc_asid  (mmu_page_entry_high),
      .cyc_fetch (cyc_fetch),
      .cyc_write (cyc_write),
      .cyc_size  (cyc_size),
      .cyc_data  (cyc_data),
      .cfg_addr  (addr_b_r),
      .cfg_asid  (asid_b_r),
      .cfg_mask  (mask_b_r),
      .cfg_cond  (cond_b_r),
      .cfg_data  (data_b_r),
      .cfg_dmask (dmask_b_r),
      .cfg_den   (ctl_r[`BCU_CTL_DATA_COND_ENABLE_B]),
      .hit       (hit_b)
   );

   // address decode and access width check
   always_comb begin
      dec_hit   = 1'b1;
      need_size = bcu_pkg::BCU_SZ_LONG;
      rd_val    = 32'h00000000;
      unique case (reg_addr)
         `BCU_OFS_ADDR_A:  rd_val = addr_a_r;
         `BCU_OFS_ADDR_B:  rd_val = addr_b_r;
         `BCU_OFS_DATA_B:  rd_val = data_b_r;
         `BCU_OFS_DMASK_B: rd_val = dmask_b_r;
         `BCU_OFS_ASID_A: begin
            need_size = bcu_pkg::BCU_SZ_BYTE;
            rd_val    = {24'h000000, asid_a_r};
         end
         `BCU_OFS_ASID_B: begin
            need_size = bcu_pkg::BCU_SZ_BYTE;
            rd_val    = {24'h000000, asid_b_r};
         end
         `BCU_OFS_MASK_A: begin
            need_size = bcu_pkg::BCU_SZ_BYTE;
            rd_val    = {24'h000000, mask_a_r};
         end
         `BCU_OFS_MASK_B: begin
            need_size = bcu_pkg::BCU_SZ_BYTE;
            rd_val    = {24'h000000, mask_b_r};
         end
         `BCU_OFS_COND_A: begin
            need_size = bcu_pkg::BCU_SZ_WORD;
            rd_val    = {16'h0000, cond_a_r};
         end
         `BCU_OFS_COND_B: begin
            need_size = bcu_pkg::BCU_SZ_WORD;
            rd_val    = {16'h0000, cond_b_r};
         end
         `BCU_OFS_CTL: begin
            need_size = bcu_pkg::BCU_SZ_WORD;
            rd_val    = {16'h0000, ctl_r};
         end
         default: dec_hit = 1'b0;
      endcase
      acc_ok = dec_hit && (reg_size == need_size);
      wr_ok  = reg_wr && acc_ok;
   end

   // match and break decision
   always_comb begin
      a_m    = cyc_valid && hit_a;
      b_m    = cyc_valid && hit_b;
      seq_on = ctl_r[`BCU_CTL_SEQ];
      if (seq_on) begin
         brk         = b_m && seq_rec_r;
         seq_rec_nxt = a_m || (seq_rec_r && !brk);
      end else begin
         brk         = a_m || b_m;
         seq_rec_nxt = 1'b0;
      end
   end

   // reset group next values
   always_comb begin
      cond_a_nxt     = cond_a_r;
      cond_b_nxt     = cond_b_r;
      ctl_nxt        = ctl_r;
      break_req_nxt  = brk;
      break_post_nxt = 1'b0;
      ack_nxt        = reg_wr || reg_rd;
      err_nxt        = (reg_wr || reg_rd) && !acc_ok;
      rdata_nxt      = (reg_rd && acc_ok) ? rd_val : 32'h00000000;
      if (wr_ok) begin
         unique case (reg_addr)
            `BCU_OFS_COND_A: cond_a_nxt = reg_wdata[15:0] & `BCU_COND_WMASK;
            `BCU_OFS_COND_B: cond_b_nxt = reg_wdata[15:0] & `BCU_COND_WMASK;
            `BCU_OFS_CTL:    ctl_nxt    = reg_wdata[15:0] & `BCU_CTL_WMASK;
            default: ;
         endcase
      end
      // set wins so a break in the clearing cycle is not lost
      if (brk) begin
         ctl_nxt[`BCU_CTL_MFA] = 1'b1;
         ctl_nxt[`BCU_CTL_MFB] = 1'b1;
      end
      // fetch break timing from the channel that caused it, A first
      if (brk && cyc_fetch) begin
         if (!seq_on && a_m) begin
            break_post_nxt = ctl_r[`BCU_CTL_FETCH_TIMING_SEL_A];
         end else begin
            break_post_nxt = ctl_r[`BCU_CTL_FETCH_TIMING_SEL_B];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cond_a_r     <= `BCU_COND_RST;
         cond_b_r     <= `BCU_COND_RST;
         ctl_r        <= `BCU_CTL_RST;
         seq_rec_r    <= 1'b0;
         break_req_r  <= 1'b0;
         break_post_r <= 1'b0;
         rdata_r      <= 32'h00000000;
         ack_r        <= 1'b0;
         err_r        <= 1'b0;
      end else begin
         cond_a_r     <= cond_a_nxt;
         cond_b_r     <= cond_b_nxt;
         ctl_r        <= ctl_nxt;
         seq_rec_r    <= seq_rec_nxt;
         break_req_r  <= break_req_nxt;
         break_post_r <= break_post_nxt;
         rdata_r      <= rdata_nxt;
         ack_r        <= ack_nxt;
         err_r        <= err_nxt;
      end
   end

   // retained group, no standby input exists so nothing disturbs it
   always_comb begin
      addr_a_nxt  = addr_a_r;
      addr_b_nxt  = addr_b_r;
      asid_a_nxt  = asid_a_r;
      asid_b_nxt  = asid_b_r;
      mask_a_nxt  = mask_a_r;
      mask_b_nxt  = mask_b_r;
      data_b_nxt  = data_b_r;
      dmask_b_nxt = dmask_b_r;
      if (wr_ok) begin
         unique case (reg_addr)
            `BCU_OFS_ADDR_A:  addr_a_nxt  = reg_wdata;
            `BCU_OFS_ADDR_B:  addr_b_nxt  = reg_wdata;
            `BCU_OFS_ASID_A:  asid_a_nxt  = reg_wdata[7:0];
            `BCU_OFS_ASID_B:  asid_b_nxt  = reg_wdata[7:0];
            `BCU_OFS_MASK_A:  mask_a_nxt  = reg_wdata[7:0] & `BCU_MASK_WMASK;
            `BCU_OFS_MASK_B:  mask_b_nxt  = reg_wdata[7:0] & `BCU_MASK_WMASK;
            `BCU_OFS_DATA_B:  data_b_nxt  = reg_wdata;
            `BCU_OFS_DMASK_B: dmask_b_nxt = reg_wdata;
            default: ;
         endcase
      end
   end

   // no reset term: contents survive every reset and start undefined
   always_ff @(posedge clk) begin
      addr_a_r  <= addr_a_nxt;
      addr_b_r  <= addr_b_nxt;
      asid_a_r  <= asid_a_nxt;
      asid_b_r  <= asid_b_nxt;
      mask_a_r  <= mask_a_nxt;
      mask_b_r  <= mask_b_nxt;
      data_b_r  <= data_b_nxt;
      dmask_b_r <= dmask_b_nxt;
   end

   assign reg_rdata  = rdata_r;
   assign reg_ack    = ack_r;
   assign reg_err    = err_r;
   assign break_req  = break_req_r;
   assign break_post = break_post_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_arm_a;
      seq_on && a_m && !b_m;
   endsequence

   sequence s_then_b;
      seq_on && b_m && !a_m;
   endsequence

   // a cycle with no B match between, as the processor side leaves a gap after each cycle
   sequence s_gap;
      seq_on && !b_m;
   endsequence

   a_seq_a_then_b: assert property (s_arm_a ##1 s_gap ##1 s_then_b |=> break_req_r)
      else $error("sequential A then B gave no break");
   a_seq_b_alone: assert property (seq_on && !seq_rec_r && b_m |=> !break_req_r)
      else $error("sequential break without prior A match");
   a_indep_channel: assert property (!seq_on && (a_m || b_m) |=> break_req_r)
      else $error("independent match gave no break");
   a_break_flags: assert property (break_req_r |-> ctl_r[`BCU_CTL_MFA] && ctl_r[`BCU_CTL_MFB])
      else $error("break without both match flags");
   a_flag_sticky: assert property (ctl_r[`BCU_CTL_MFA] && !(wr_ok && reg_addr == `BCU_OFS_CTL)
                                   |=> ctl_r[`BCU_CTL_MFA])
      else $error("match flag cleared by hardware");
   a_seq_record: assert property (s_arm_a |=> seq_rec_r ##0 !break_req_r)
      else $error("A match not recorded in sequential mode");
   a_seq_consume: assert property (seq_on && brk && !a_m |=> !seq_rec_r)
      else $error("sequential record not consumed");
   a_post_timing: assert property (!seq_on && a_m && cyc_fetch |=>
                                   break_post_r == $past(ctl_r[`BCU_CTL_FETCH_TIMING_SEL_A]))
      else $error("fetch break timing wrong for channel A");
   a_width_refused: assert property ((reg_wr || reg_rd) && dec_hit && reg_size != need_size
                                     |=> ack_r && err_r)
      else $error("wrong width access not flagged");
   a_cond_reset: assert property (disable iff (1'b0) rst |=> cond_a_r == `BCU_COND_RST
                                  && cond_b_r == `BCU_COND_RST && ctl_r == `BCU_CTL_RST)
      else $error("condition registers not cleared by reset");

endmodule : bcu_top

// file: tb/bcu_cpu_model.sv
// processor side: one bus cycle per call, address, data, fetch and write lines scrambled once released
module bcu_cpu_model (
   input  wire logic               clk,
   output logic                    cyc_valid,
   output logic [31:0]             cyc_addr,
   output logic [31:0]             cyc_data,
   output logic                    cyc_fetch,
   output logic                    cyc_write,
   output bcu_pkg::bcu_size_e      cyc_size,
   output bcu_pkg::bcu_asid_t      mmu_page_entry_high
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      cyc_valid           = 1'b0;
      cyc_addr            = 32'h00000000;
      cyc_data            = 32'h00000000;
      cyc_fetch           = 1'b0;
      cyc_write           = 1'b0;
      cyc_size            = bcu_pkg::BCU_SZ_LONG;
      mmu_page_entry_high = 8'h00;
   end

   // one cycle per call, valid for exactly one edge
   task automatic drive(input logic [31:0] a, input logic [31:0] d, input logic f,
                        input logic w, input bcu_pkg::bcu_size_e s,
                        input bcu_pkg::bcu_asid_t id);
      @(posedge clk);
      cyc_valid           <= 1'b1;
      cyc_addr            <= a;
      cyc_data            <= d;
      cyc_fetch           <= f;
      cyc_write           <= w;
      cyc_size            <= s;
      mmu_page_entry_high <= id;
      @(posedge clk);
      // inverted leftovers so stale values never fake a match
      cyc_valid <= 1'b0;
      cyc_addr  <= ~a;
      cyc_data  <= ~d;
      cyc_fetch <= ~f;
      cyc_write <= ~w;
      #1;
   endtask : drive
endmodule : bcu_cpu_model

// file: tb/tb_top.sv
`include "bcu_map.svh"
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin n_fail++; \
   $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam bcu_pkg::bcu_size_e SZ_B  = bcu_pkg::BCU_SZ_BYTE;
   localparam bcu_pkg::bcu_size_e SZ_W  = bcu_pkg::BCU_SZ_WORD;
   localparam bcu_pkg::bcu_size_e SZ_L  = bcu_pkg::BCU_SZ_LONG;
   localparam logic [31:0]        A_ADR = 32'h12345678;
   localparam logic [31:0]        B_ADR = 32'hA0000000;
   logic               clk;
   logic               rst;
   logic [31:0]        reg_addr;
   logic               reg_wr;
   logic               reg_rd;
   bcu_pkg::bcu_size_e reg_size;
   logic [31:0]        reg_wdata;
   logic [31:0]        reg_rdata;
   logic               reg_ack;
   logic               reg_err;
   logic               cyc_valid;
   logic [31:0]        cyc_addr;
   logic [31:0]        cyc_data;
   logic               cyc_fetch;
   logic               cyc_write;
   bcu_pkg::bcu_size_e cyc_size;
   bcu_pkg::bcu_asid_t asid;
   logic               break_req;
   logic               break_post;
   int                 n_fail;
   int                 n_tests;
   logic [15:0]        ctl_base;
   logic [31:0]        rd;
   logic               er;
   logic [31:0]        flip [3];

   bcu_top i_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_size(reg_size), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_ack(reg_ack), .reg_err(reg_err), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
      .cyc_data(cyc_data), .cyc_fetch(cyc_fetch), .cyc_write(cyc_write),
      .cyc_size(cyc_size), .mmu_page_entry_high(asid), .break_req(break_req),
      .break_post(break_post));

   bcu_cpu_model i_cpu (.clk(clk), .cyc_valid(cyc_valid), .cyc_addr(cyc_addr),
      .cyc_data(cyc_data), .cyc_fetch(cyc_fetch), .cyc_write(cyc_write),
      .cyc_size(cyc_size), .mmu_page_entry_high(asid));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic summarize();
      $display("tests %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   task automatic acc(input logic w, input logic [31:0] a, input bcu_pkg::bcu_size_e s,
                      input logic [31:0] wd);
      @(posedge clk);
      reg_wr    <= w;
      reg_rd    <= ~w;
      reg_addr  <= a;
      reg_size  <= s;
      reg_wdata <= wd;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      `CHK("reg_ack", 1'b1, reg_ack)
      rd = reg_rdata;
      er = reg_err;
   endtask : acc

   task automatic wr(input logic [31:0] a, input bcu_pkg::bcu_size_e s, input logic [31:0] wd);
      acc(1'b1, a, s, wd);
      `CHK("reg_err", 1'b0, er)
   endtask : wr

   task automatic rchk(input logic [31:0] a, input bcu_pkg::bcu_size_e s,
                       input logic [31:0] exp);
      acc(1'b0, a, s, 32'h00000000);
      `CHK("reg_rdata", exp, rd)
      `CHK("reg_err", 1'b0, er)
   endtask : rchk

   // one bus cycle; a break is answered by clearing the flags again
   task automatic cyc(input logic [31:0] a, input logic [31:0] d, input logic f,
                      input logic w, input bcu_pkg::bcu_size_e s,
                      input bcu_pkg::bcu_asid_t id, input logic h);
      i_cpu.drive(a, d, f, w, s, id);
      `CHK("break_req", h, break_req)
      if (h && f)
         `CHK("break_post", ctl_base[`BCU_CTL_FETCH_TIMING_SEL_A], break_post)
      if (h)
         wr(`BCU_OFS_CTL, SZ_W, {16'h0000, ctl_base});
   endtask : cyc

   task automatic do_reset();
      @(posedge clk);
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
   endtask : do_reset

   initial begin
      #100000;
      n_fail++;
      summarize();
   end

   initial begin
      rst = 1'b1;
      reg_addr = 32'h00000000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_size = SZ_L;
      reg_wdata = 32'h00000000;
      n_fail = 0;
      n_tests = 0;
      ctl_base = 16'h0000;
      flip = '{32'h00000200, 32'h00000800, 32'h80000000};
      do_reset();
      rchk(`BCU_OFS_COND_A, SZ_W, 32'h00000000);
      rchk(`BCU_OFS_COND_B, SZ_W, 32'h00000000);
      rchk(`BCU_OFS_CTL, SZ_W, 32'h00000000);
      acc(1'b0, 32'h00000000, SZ_L, 32'h00000000);
      `CHK("unmapped err", 1'b1, er)
      `CHK("unmapped rdata", 32'h00000000, rd)
      wr(`BCU_OFS_ADDR_A, SZ_L, A_ADR);
      rchk(`BCU_OFS_ADDR_A, SZ_L, A_ADR);
      wr(`BCU_OFS_ADDR_B, SZ_L, B_ADR);
      rchk(`BCU_OFS_ADDR_B, SZ_L, B_ADR);
      wr(`BCU_OFS_ASID_A, SZ_B, 32'h0000005A);
      rchk(`BCU_OFS_ASID_A, SZ_B, 32'h0000005A);
      wr(`BCU_OFS_ASID_B, SZ_B, 32'h00000033);
      rchk(`BCU_OFS_ASID_B, SZ_B, 32'h00000033);
      wr(`BCU_OFS_MASK_A, SZ_B, 32'h000000FF);
      rchk(`BCU_OFS_MASK_A, SZ_B, 32'h00000007);
      acc(1'b0, `BCU_OFS_ADDR_A, SZ_B, 32'h00000000);
      `CHK("width err", 1'b1, er)
      acc(1'b1, `BCU_OFS_COND_A, SZ_L, 32'h0000003F);
      `CHK("width err", 1'b1, er)
      rchk(`BCU_OFS_COND_A, SZ_W, 32'h00000000);
      wr(`BCU_OFS_DATA_B, SZ_L, 32'hDEADBEEF);
      rchk(`BCU_OFS_DATA_B, SZ_L, 32'hDEADBEEF);
      wr(`BCU_OFS_DMASK_B, SZ_L, 32'h000000FF);
      rchk(`BCU_OFS_DMASK_B, SZ_L, 32'h000000FF);
      $display("test registers done");

      wr(`BCU_OFS_MASK_A, SZ_B, 32'h00000000);
      wr(`BCU_OFS_COND_A, SZ_W, 32'h00000014);
      ctl_base = 16'h0400;
      wr(`BCU_OFS_CTL, SZ_W, 32'h00000400);
      i_cpu.drive(A_ADR, 32'h00000000, 1'b1, 1'b0, SZ_L, 8'h5A);
      `CHK("break_req", 1'b1, break_req)
      `CHK("break_post", 1'b1, break_post)
      rchk(`BCU_OFS_CTL, SZ_W, 32'h0000C400);
      repeat (3) @(posedge clk);
      rchk(`BCU_OFS_CTL, SZ_W, 32'h0000C400);
      wr(`BCU_OFS_CTL, SZ_W, 32'h00000400);
      rchk(`BCU_OFS_CTL, SZ_W, 32'h00000400);
      ctl_base = 16'h0000;
      wr(`BCU_OFS_CTL, SZ_W, 32'h00000000);
      cyc(A_ADR, 32'h00000000, 1'b1, 1'b0, SZ_L, 8'h5A, 1'b1);
      cyc(A_ADR, 32'h00000000, 1'b1, 1'b0, SZ_L, 8'h5B, 1'b0);
      wr(`BCU_OFS_MASK_A, SZ_B, 32'h00000004);
      cyc(A_ADR, 32'h00000000, 1'b1, 1'b0, SZ_L, 8'h5B, 1'b1);
      for (int m = 0; m < 4; m++) begin
         wr(`BCU_OFS_MASK_A, SZ_B, m);
         for (int k = 0; k < 3; k++)
            cyc(A_ADR ^ flip[k], 32'h0, 1'b1, 1'b0, SZ_L, 8'h5A, m > k);
      end
      $display("test channel a done");

      for (int k = 0; k < 4; k++) begin
         for (int d = 0; d < 4; d++) begin
            wr(`BCU_OFS_COND_A, SZ_W, {26'h0, k[1:0], d[1:0], 2'b00});
            for (int t = 0; t < 4; t++)
               cyc(A_ADR, 32'h0, t[1], t[0], SZ_L, 8'h5A, (k != 0 || d != 0)
                  && (k == 0 || k == 3 || k == (t[1] ? 1 : 2))
                  && (d == 0 || d == 3 || d == (t[0] ? 2 : 1)));
         end
      end
      for (int s = 0; s < 4; s++) begin
         wr(`BCU_OFS_COND_A, SZ_W, 32'h0000003C | s);
         for (int z = 1; z < 4; z++)
            cyc(A_ADR, 32'h0, 1'b0, 1'b1, bcu_pkg::bcu_size_e'(z), 8'h5A,
               s == 0 || s == z);
      end
      $display("test conditions done");

      wr(`BCU_OFS_COND_A, SZ_W, 32'h00000000);
      wr(`BCU_OFS_MASK_B, SZ_B, 32'h00000004);
      wr(`BCU_OFS_COND_B, SZ_W, 32'h00000028);
      ctl_base = 16'h0080;
      wr(`BCU_OFS_CTL, SZ_W, 32'h00000080);
      cyc(B_ADR, 32'hDEADBE00, 1'b0, 1'b1, SZ_L, 8'h5A, 1'b1);
      cyc(B_ADR, 32'hDEACBEEF, 1'b0, 1'b1, SZ_L, 8'h5A, 1'b0);
      ctl_base = 16'h0000;
      wr(`BCU_OFS_CTL, SZ_W, 32'h00000000);
      cyc(B_ADR, 32'hDEACBEEF, 1'b0, 1'b1, SZ_L, 8'h5A, 1'b1);
      wr(`BCU_OFS_COND_B, SZ_W, 32'h00000014);
      wr(`BCU_OFS_CTL, SZ_W, 32'h00000040);
      i_cpu.drive(B_ADR, 32'h0, 1'b1, 1'b0, SZ_L, 8'h5A);
      `CHK("break_req", 1'b1, break_req)
      `CHK("break_post b", 1'b1, break_post)
      @(posedge clk);
      #1;
      `CHK("break_req pulse", 1'b0, break_req)
      wr(`BCU_OFS_CTL, SZ_W, 32'h00000000);
      wr(`BCU_OFS_COND_B, SZ_W, 32'h00000028);
      $display("test channel b done");

      wr(`BCU_OFS_COND_A, SZ_W, 32'h00000014);
      wr(`BCU_OFS_MASK_A, SZ_B, 32'h00000000);
      ctl_base = 16'h0008;
      wr(`BCU_OFS_CTL, SZ_W, 32'h00000008);
      cyc(B_ADR, 32'h0, 1'b0, 1'b1, SZ_L, 8'h5A, 1'b0);
      cyc(A_ADR, 32'h0, 1'b1, 1'b0, SZ_L, 8'h5A, 1'b0);
      cyc(B_ADR, 32'h0, 1'b0, 1'b1, SZ_L, 8'h5A, 1'b1);
      cyc(B_ADR, 32'h0, 1'b0, 1'b1, SZ_L, 8'h5A, 1'b0);
      $display("test sequential done");

      do_reset();
      rchk(`BCU_OFS_ADDR_A, SZ_L, A_ADR);
      rchk(`BCU_OFS_ASID_B, SZ_B, 32'h00000033);
      rchk(`BCU_OFS_DATA_B, SZ_L, 32'hDEADBEEF);
      rchk(`BCU_OFS_COND_A, SZ_W, 32'h00000000);
      rchk(`BCU_OFS_CTL, SZ_W, 32'h00000000);
      cyc(A_ADR, 32'h0, 1'b1, 1'b0, SZ_L, 8'h5A, 1'b0);
      $display("test reset done");
      summarize();
   end
endmodule : tb_top
